// ==== design/blk_pkg.sv ====
package blk_pkg;
  localparam int CRED_W = 256;
  localparam int KEY_W = 256;
  localparam int LBA_W = 48;
  localparam int BANDS = 16;
  localparam int BAND_W = 4;
  localparam int ALIGN_BITS = 12;
  localparam int LANES = 8;
  // ---------------------------------------------------------------
  // opcodes and actions
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_SEC_OUT = 8'hb5;
  localparam logic [7:0] OP_SEC_IN = 8'ha2;
  localparam logic [7:0] OP_SANITIZE = 8'h48;
  localparam logic [7:0] OP_READ = 8'h28;
  localparam logic [7:0] OP_WRITE = 8'h2a;
  localparam logic [3:0] SAN_CRYPT = 4'h3;
  localparam logic [3:0] ACT_SET_CRED = 4'h0;
  localparam logic [3:0] ACT_FW_PORT = 4'h1;
  localparam logic [3:0] ACT_RANGE = 4'h2;
  localparam logic [3:0] ACT_ENABLE = 4'h3;
  localparam logic [3:0] ACT_LOCK = 4'h4;
  localparam logic [3:0] ACT_ERASE = 4'h5;
  localparam logic [3:0] ACT_REVERT = 4'h6;
  localparam logic [3:0] ACT_FW_LOAD = 4'h7;
  localparam logic [3:0] ACT_GET_RANDOM = 4'h0;
  localparam logic [3:0] ACT_GET_FACTORY = 4'h1;
  localparam logic [1:0] TGT_OWNER = 2'h0;
  localparam logic [1:0] TGT_ERASE = 2'h1;
  localparam logic [1:0] TGT_BAND = 2'h2;
  // ---------------------------------------------------------------
  // flag positions
  // ---------------------------------------------------------------
  localparam int FLG_TRIG = 0;
  localparam int FLG_RDARM = 1;
  localparam int FLG_WRARM = 2;
  localparam int FLG_UNLOCK = 3;
  localparam int FLG_OPEN = 0;
  localparam int FLG_SED = 0;
  localparam int FLG_SIGNED = 1;
  localparam int FLG_ACCEPT = 2;
  // ---------------------------------------------------------------
  // status and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] STS_GOOD = 2'h0;
  localparam logic [1:0] STS_DENIED = 2'h1;
  localparam logic [1:0] STS_REFUSED = 2'h2;
  localparam logic [1:0] STS_BAD = 2'h3;
  localparam logic RST_FW_OPEN = 1'b1;
  // arbitrary neutral values
  localparam logic [CRED_W-1:0] DEF_FACTORY_CRED = {8{32'h5e5e_a1a1}};
  localparam logic [CRED_W-1:0] DEF_LABEL_CRED = {8{32'h3c3c_9696}};
  localparam logic [31:0] LFSR_SEED = 32'hace1_0001;
  localparam logic [31:0] LFSR_TAPS = 32'h8020_0003;

  typedef struct packed {
    logic [7:0] op;
    logic [3:0] act;
    logic [BAND_W-1:0] band;
    logic [1:0] target;
    logic [3:0] flags;
    logic [CRED_W-1:0] cred;
    logic [CRED_W-1:0] arg;
    logic [LBA_W-1:0] lba;
    logic [LBA_W-1:0] len;
  } blk_cmd_t;

  typedef enum logic [1:0] {S_INIT, S_WALK, S_RUN} blk_state_t;
endpackage

// ==== design/blk_link_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface blk_link_if;
  logic cmdValid;
  logic cmdReady;
  blk_pkg::blk_cmd_t cmd;
  logic rspValid;
  logic [1:0] rspStatus;
  logic [blk_pkg::CRED_W-1:0] rspData;
  modport dev (input cmdValid, input cmd, output cmdReady, output rspValid, output rspStatus, output rspData);
  modport host (output cmdValid, output cmd, input cmdReady, input rspValid, input rspStatus, input rspData);
endinterface
`default_nettype wire

// ==== design/blk_fifo.sv ====
`timescale 1ns/100ps
`default_nettype none
module blk_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("depth must be a power of two, at least 2");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_q, wr_d, rd_q, rd_d, cnt;
  logic ready_q, ready_d, push, pop;

  assign push = inValid && ready_q;
  assign pop = outReady && outValid;
  assign outValid = (wr_q != rd_q);
  assign outData = mem[rd_q[AW-1:0]];
  assign inReady = ready_q;

  always_comb begin
    wr_d = wr_q + (AW+1)'(push);
    rd_d = rd_q + (AW+1)'(pop);
    cnt = wr_d - rd_d;
    // registered ready: space after this cycle's traffic
    ready_d = (cnt != (AW+1)'(DEPTH));
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      ready_q <= 1'b0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      ready_q <= ready_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= inData;
    end
  end
endmodule
`default_nettype wire

// ==== design/blk_device.sv ====
`timescale 1ns/100ps
`default_nettype none
module blk_device #(
  parameter int FIFO_DEPTH = 8,
  parameter logic [blk_pkg::CRED_W-1:0] FACTORY_CRED = blk_pkg::DEF_FACTORY_CRED,
  parameter logic [blk_pkg::CRED_W-1:0] LABEL_CRED = blk_pkg::DEF_LABEL_CRED
) (
  input wire logic mclk,
  input wire logic rst,
  blk_link_if.dev link,
  input wire logic powerLoss,
  output logic [blk_pkg::KEY_W-1:0] mediaKey,
  output logic [blk_pkg::BAND_W-1:0] mediaBand,
  output logic mediaStrobe,
  output logic mediaWrite,
  output logic fwAccept
);
  localparam int NB = blk_pkg::BANDS;
  localparam int LW = blk_pkg::LBA_W;
  localparam int CW = blk_pkg::CRED_W;
  if (FIFO_DEPTH < 2) begin : g_bad_depth
    $error("fifo depth below 2");
  end

  // ---------------------------------------------------------------
  // command buffer
  // ---------------------------------------------------------------
  blk_pkg::blk_cmd_t c;
  logic fValid, popCmd;
  blk_fifo #(.WIDTH($bits(blk_pkg::blk_cmd_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .rst(rst),
    .inValid(link.cmdValid),
    .inReady(link.cmdReady),
    .inData(link.cmd),
    .outValid(fValid),
    .outReady(popCmd),
    .outData(c)
  );

  // ---------------------------------------------------------------
  // random source
  // ---------------------------------------------------------------
  logic [31:0] lfsr_q [blk_pkg::LANES];
  logic [blk_pkg::KEY_W-1:0] randWord;
  for (genvar g = 0; g < blk_pkg::LANES; g++) begin : g_lane
    logic [31:0] lfsr_d;
    assign lfsr_d = {lfsr_q[g][30:0], 1'b0} ^ (lfsr_q[g][31] ? blk_pkg::LFSR_TAPS : 32'h0);
    assign randWord[g*32 +: 32] = lfsr_q[g];
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        lfsr_q[g] <= blk_pkg::LFSR_SEED ^ 32'(g * 32'h0101_3579);
      end else begin
        lfsr_q[g] <= lfsr_d;
      end
    end
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  blk_pkg::blk_state_t st_q, st_d;
  logic [3:0] walk_q, walk_d;
  logic walkRsp_q, walkRsp_d;
  logic [CW-1:0] wrap_q, wrap_d, ownerCred_q, ownerCred_d, eraseCred_q, eraseCred_d;
  logic [CW-1:0] bandCred_q [NB];
  logic [CW-1:0] bandCred_d [NB];
  logic [blk_pkg::KEY_W-1:0] keyStore_q [NB];
  logic [blk_pkg::KEY_W-1:0] keyStore_d [NB];
  logic [LW-1:0] bStart_q [NB];
  logic [LW-1:0] bStart_d [NB];
  logic [LW-1:0] bEnd_q [NB];
  logic [LW-1:0] bEnd_d [NB];
  logic [NB-1:0] bDef_q, bDef_d, bEn_q, bEn_d, trig_q, trig_d;
  logic [NB-1:0] rdArm_q, rdArm_d, wrArm_q, wrArm_d, locked_q, locked_d;
  logic fwOpen_q, fwOpen_d;
  logic rspValid_q, rspValid_d;
  logic [1:0] rspStatus_q, rspStatus_d;
  logic [CW-1:0] rspData_q, rspData_d;
  logic [blk_pkg::KEY_W-1:0] mKey_q, mKey_d;
  logic [blk_pkg::BAND_W-1:0] mBand_q, mBand_d;
  logic mStrobe_q, mStrobe_d, mWrite_q, mWrite_d, fwAcc_q, fwAcc_d;

  // band that owns an address; no match falls to band 0
  function automatic logic [blk_pkg::BAND_W-1:0] bandLookup(input logic [LW-1:0] lba);
    bandLookup = '0;
    for (int i = NB - 1; i >= 1; i--) begin
      if (bDef_q[i] && lba >= bStart_q[i] && lba <= bEnd_q[i]) begin
        bandLookup = blk_pkg::BAND_W'(i);
      end
    end
  endfunction

  logic [LW:0] lbaEnd;
  logic ownerOk, eraseOk, bandOk, clash;
  logic [blk_pkg::BAND_W-1:0] hitBand;

  always_comb begin
    st_d = st_q;
    walk_d = walk_q;
    walkRsp_d = walkRsp_q;
    wrap_d = wrap_q;
    ownerCred_d = ownerCred_q;
    eraseCred_d = eraseCred_q;
    bandCred_d = bandCred_q;
    keyStore_d = keyStore_q;
    bStart_d = bStart_q;
    bEnd_d = bEnd_q;
    bDef_d = bDef_q;
    bEn_d = bEn_q;
    trig_d = trig_q;
    rdArm_d = rdArm_q;
    wrArm_d = wrArm_q;
    locked_d = locked_q;
    fwOpen_d = fwOpen_q;
    rspValid_d = 1'b0;
    rspStatus_d = rspStatus_q;
    rspData_d = rspData_q;
    mKey_d = mKey_q;
    mBand_d = mBand_q;
    mStrobe_d = 1'b0;
    mWrite_d = mWrite_q;
    fwAcc_d = 1'b0;
    popCmd = 1'b0;
    lbaEnd = {1'b0, c.lba} + {1'b0, c.len} - (LW+1)'(1);
    ownerOk = (c.cred == ownerCred_q) || (c.cred == FACTORY_CRED);
    eraseOk = (c.cred == eraseCred_q);
    bandOk = (c.cred == bandCred_q[c.band]);
    hitBand = bandLookup(c.lba);
    clash = 1'b0;
    for (int i = 1; i < NB; i++) begin
      // inclusive ends: touching ranges pass, shared blocks clash
      if (bDef_q[i] && i != int'(c.band) && c.lba <= bEnd_q[i] && lbaEnd[LW-1:0] >= bStart_q[i]) begin
        clash = 1'b1;
      end
    end
    unique case (st_q)
      blk_pkg::S_INIT: begin
        wrap_d = randWord;
        st_d = blk_pkg::S_WALK;
      end
      blk_pkg::S_WALK: begin
        // one band per cycle; keys stay wrapped at rest
        keyStore_d[walk_q] = randWord ^ wrap_q;
        walk_d = walk_q + 4'h1;
        if (walk_q == 4'hf) begin
          st_d = blk_pkg::S_RUN;
          rspValid_d = walkRsp_q;
          rspStatus_d = blk_pkg::STS_GOOD;
          walkRsp_d = 1'b0;
        end
      end
      blk_pkg::S_RUN: if (fValid) begin
        popCmd = 1'b1;
        rspValid_d = 1'b1;
        rspStatus_d = blk_pkg::STS_GOOD;
        rspData_d = '0;
        if (c.op == blk_pkg::OP_READ || c.op == blk_pkg::OP_WRITE) begin
          if (locked_q[hitBand]) begin
            rspStatus_d = blk_pkg::STS_REFUSED;
          end else begin
            // clear key leaves only toward the cipher, never the link
            mKey_d = keyStore_q[hitBand] ^ wrap_q;
            mBand_d = hitBand;
            mStrobe_d = 1'b1;
            mWrite_d = (c.op == blk_pkg::OP_WRITE);
          end
        end else if (c.op == blk_pkg::OP_SANITIZE) begin
          if (c.act == blk_pkg::SAN_CRYPT) begin
            st_d = blk_pkg::S_WALK;
            walk_d = 4'h0;
            walkRsp_d = 1'b1;
            rspValid_d = 1'b0;
          end else begin
            rspStatus_d = blk_pkg::STS_BAD;
          end
        end else if (c.op == blk_pkg::OP_SEC_IN) begin
          if (c.act == blk_pkg::ACT_GET_RANDOM) begin
            rspData_d = randWord;
          end else if (c.act == blk_pkg::ACT_GET_FACTORY) begin
            rspData_d = FACTORY_CRED;
          end else begin
            rspStatus_d = blk_pkg::STS_BAD;
          end
        end else if (c.op == blk_pkg::OP_SEC_OUT) begin
          rspStatus_d = blk_pkg::STS_DENIED;
          unique case (c.act)
            blk_pkg::ACT_SET_CRED: begin
              if (c.target == blk_pkg::TGT_OWNER && ownerOk) begin
                ownerCred_d = c.arg;
                rspStatus_d = blk_pkg::STS_GOOD;
              end else if (c.target == blk_pkg::TGT_ERASE && eraseOk) begin
                eraseCred_d = c.arg;
                rspStatus_d = blk_pkg::STS_GOOD;
              end else if (c.target == blk_pkg::TGT_BAND && bandOk) begin
                bandCred_d[c.band] = c.arg;
                rspStatus_d = blk_pkg::STS_GOOD;
              end
            end
            blk_pkg::ACT_FW_PORT: if (ownerOk) begin
              fwOpen_d = c.flags[blk_pkg::FLG_OPEN];
              rspStatus_d = blk_pkg::STS_GOOD;
            end
            blk_pkg::ACT_RANGE: begin
              if (c.band == '0 || c.len == '0 || lbaEnd[LW]) begin
                rspStatus_d = blk_pkg::STS_BAD;
              end else if (bandOk || eraseOk) begin
                if ((c.band >= 4'h2 && !bEn_q[c.band]) || clash) begin
                  rspStatus_d = blk_pkg::STS_REFUSED;
                end else begin
                  bStart_d[c.band] = c.lba;
                  bEnd_d[c.band] = lbaEnd[LW-1:0];
                  bDef_d[c.band] = 1'b1;
                  rspStatus_d = blk_pkg::STS_GOOD;
                end
              end
            end
            blk_pkg::ACT_ENABLE: if (eraseOk) begin
              if (c.band >= 4'h2) begin
                bEn_d[c.band] = 1'b1;
                rspStatus_d = blk_pkg::STS_GOOD;
              end else begin
                rspStatus_d = blk_pkg::STS_BAD;
              end
            end
            blk_pkg::ACT_LOCK: if (bandOk) begin
              trig_d[c.band] = c.flags[blk_pkg::FLG_TRIG];
              rdArm_d[c.band] = c.flags[blk_pkg::FLG_RDARM];
              wrArm_d[c.band] = c.flags[blk_pkg::FLG_WRARM];
              if (c.flags[blk_pkg::FLG_UNLOCK]) begin
                locked_d[c.band] = 1'b0;
              end
              rspStatus_d = blk_pkg::STS_GOOD;
            end
            blk_pkg::ACT_ERASE: if (bandOk || eraseOk) begin
              keyStore_d[c.band] = randWord ^ wrap_q;
              rspStatus_d = blk_pkg::STS_GOOD;
            end
            blk_pkg::ACT_REVERT: if (c.cred == LABEL_CRED) begin
              ownerCred_d = FACTORY_CRED;
              eraseCred_d = FACTORY_CRED;
              for (int i = 0; i < NB; i++) begin
                bandCred_d[i] = FACTORY_CRED;
              end
              bDef_d = '0;
              bEn_d = '0;
              trig_d = '0;
              rdArm_d = '0;
              wrArm_d = '0;
              locked_d = '0;
              fwOpen_d = blk_pkg::RST_FW_OPEN;
              st_d = blk_pkg::S_WALK;
              walk_d = 4'h0;
              walkRsp_d = 1'b1;
              rspValid_d = 1'b0;
            end
            blk_pkg::ACT_FW_LOAD: begin
              if (fwOpen_q && c.flags[blk_pkg::FLG_SED] && c.flags[blk_pkg::FLG_SIGNED]
                  && c.flags[blk_pkg::FLG_ACCEPT]) begin
                fwAcc_d = 1'b1;
                rspStatus_d = blk_pkg::STS_GOOD;
              end else begin
                rspStatus_d = blk_pkg::STS_REFUSED;
              end
            end
            default: rspStatus_d = blk_pkg::STS_BAD;
          endcase
        end else begin
          rspStatus_d = blk_pkg::STS_BAD;
        end
      end
    endcase
    // power loss beats a same-cycle unlock
    if (powerLoss) begin
      locked_d = locked_d | (trig_q & rdArm_q & wrArm_q);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q <= blk_pkg::S_INIT;
      walk_q <= 4'h0;
      walkRsp_q <= 1'b0;
      wrap_q <= '0;
      ownerCred_q <= FACTORY_CRED;
      eraseCred_q <= FACTORY_CRED;
      for (int i = 0; i < NB; i++) begin
        bandCred_q[i] <= FACTORY_CRED;
        keyStore_q[i] <= '0;
        bStart_q[i] <= '0;
        bEnd_q[i] <= '0;
      end
      bDef_q <= '0;
      bEn_q <= '0;
      trig_q <= '0;
      rdArm_q <= '0;
      wrArm_q <= '0;
      locked_q <= '0;
      fwOpen_q <= blk_pkg::RST_FW_OPEN;
      rspValid_q <= 1'b0;
      rspStatus_q <= blk_pkg::STS_GOOD;
      rspData_q <= '0;
      mKey_q <= '0;
      mBand_q <= '0;
      mStrobe_q <= 1'b0;
      mWrite_q <= 1'b0;
      fwAcc_q <= 1'b0;
    end else begin
      st_q <= st_d;
      walk_q <= walk_d;
      walkRsp_q <= walkRsp_d;
      wrap_q <= wrap_d;
      ownerCred_q <= ownerCred_d;
      eraseCred_q <= eraseCred_d;
      bandCred_q <= bandCred_d;
      keyStore_q <= keyStore_d;
      bStart_q <= bStart_d;
      bEnd_q <= bEnd_d;
      bDef_q <= bDef_d;
      bEn_q <= bEn_d;
      trig_q <= trig_d;
      rdArm_q <= rdArm_d;
      wrArm_q <= wrArm_d;
      locked_q <= locked_d;
      fwOpen_q <= fwOpen_d;
      rspValid_q <= rspValid_d;
      rspStatus_q <= rspStatus_d;
      rspData_q <= rspData_d;
      mKey_q <= mKey_d;
      mBand_q <= mBand_d;
      mStrobe_q <= mStrobe_d;
      mWrite_q <= mWrite_d;
      fwAcc_q <= fwAcc_d;
    end
  end

  assign link.rspValid = rspValid_q;
  assign link.rspStatus = rspStatus_q;
  assign link.rspData = rspData_q;
  assign mediaKey = mKey_q;
  assign mediaBand = mBand_q;
  assign mediaStrobe = mStrobe_q;
  assign mediaWrite = mWrite_q;
  assign fwAccept = fwAcc_q;
endmodule
`default_nettype wire

// ==== design/blk_host.sv ====
`timescale 1ns/100ps
`default_nettype none
module blk_host (
  input wire logic mclk,
  input wire logic rst,
  blk_link_if.host link,
  input wire logic reqValid,
  output logic reqReady,
  input wire blk_pkg::blk_cmd_t reqCmd,
  output logic rspValid,
  output logic [1:0] rspStatus,
  output logic [blk_pkg::CRED_W-1:0] rspData,
  output logic misalignWarn
);
  logic pend_q, pend_d, rdy_q, rdy_d, rv_q, rv_d, warn_q, warn_d;
  blk_pkg::blk_cmd_t cmd_q, cmd_d;
  logic [1:0] rs_q, rs_d;
  logic [blk_pkg::CRED_W-1:0] rdat_q, rdat_d;

  always_comb begin
    pend_d = pend_q;
    cmd_d = cmd_q;
    warn_d = warn_q;
    if (pend_q && link.cmdReady) begin
      pend_d = 1'b0;
    end
    if (reqValid && rdy_q) begin
      pend_d = 1'b1;
      cmd_d = reqCmd;
      // boundaries off the 4096-block grid are sent but flagged
      warn_d = reqCmd.op == blk_pkg::OP_SEC_OUT && reqCmd.act == blk_pkg::ACT_RANGE
        && (reqCmd.lba[blk_pkg::ALIGN_BITS-1:0] != '0
        || reqCmd.len[blk_pkg::ALIGN_BITS-1:0] != '0);
    end
    rdy_d = !pend_d;
    rv_d = link.rspValid;
    rs_d = link.rspValid ? link.rspStatus : rs_q;
    rdat_d = link.rspValid ? link.rspData : rdat_q;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pend_q <= 1'b0;
      rdy_q <= 1'b0;
      cmd_q <= '0;
      warn_q <= 1'b0;
      rv_q <= 1'b0;
      rs_q <= blk_pkg::STS_GOOD;
      rdat_q <= '0;
    end else begin
      pend_q <= pend_d;
      rdy_q <= rdy_d;
      cmd_q <= cmd_d;
      warn_q <= warn_d;
      rv_q <= rv_d;
      rs_q <= rs_d;
      rdat_q <= rdat_d;
    end
  end

  assign link.cmdValid = pend_q;
  assign link.cmd = cmd_q;
  assign reqReady = rdy_q;
  assign rspValid = rv_q;
  assign rspStatus = rs_q;
  assign rspData = rdat_q;
  assign misalignWarn = warn_q;
endmodule
`default_nettype wire

// ==== tb/blk_link_properties.sv ====
`timescale 1ns/100ps
`default_nettype none
module blk_link_properties (
  input wire logic mclk,
  input wire logic rst,
  input wire logic cmdValid,
  input wire logic cmdReady,
  input wire blk_pkg::blk_cmd_t cmd,
  input wire logic rspValid,
  input wire logic [1:0] rspStatus,
  input wire logic [blk_pkg::CRED_W-1:0] rspData
);
  // ---------------------------------------------------------------
  // last accepted command, valid while only one is outstanding
  // ---------------------------------------------------------------
  blk_pkg::blk_cmd_t lastCmd_d;
  blk_pkg::blk_cmd_t lastCmd_q;
  logic secOut;
  always_comb begin
    lastCmd_d = lastCmd_q;
    if (cmdValid && cmdReady) begin
      lastCmd_d = cmd;
    end
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lastCmd_q <= '0;
    end else begin
      lastCmd_q <= lastCmd_d;
    end
  end
  assign secOut = rspValid && lastCmd_q.op == blk_pkg::OP_SEC_OUT;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  // ---------------------------------------------------------------
  // link properties
  // ---------------------------------------------------------------
  property p_hold;
    cmdValid && !cmdReady |=> cmdValid && $stable(cmd);
  endproperty
  a_hold: assert property (p_hold) else $error("command changed while waiting");
  property p_answer;
    cmdValid && cmdReady |-> ##[2:40] rspValid;
  endproperty
  a_answer: assert property (p_answer) else $error("command got no response");
  property p_key_hidden;
    rspValid && lastCmd_q.op != blk_pkg::OP_SEC_IN |-> rspData == '0;
  endproperty
  a_key_hidden: assert property (p_key_hidden) else $error("data returned on non-read answer");
  property p_factory;
    rspValid && lastCmd_q.op == blk_pkg::OP_SEC_IN && lastCmd_q.act == blk_pkg::ACT_GET_FACTORY
      |-> rspStatus == blk_pkg::STS_GOOD && rspData == blk_pkg::DEF_FACTORY_CRED;
  endproperty
  a_factory: assert property (p_factory) else $error("factory credential read wrong");
  property p_sanitize;
    rspValid && lastCmd_q.op == blk_pkg::OP_SANITIZE && lastCmd_q.act != blk_pkg::SAN_CRYPT
      |-> rspStatus == blk_pkg::STS_BAD;
  endproperty
  a_sanitize: assert property (p_sanitize) else $error("bad sanitize action accepted");
  property p_revert;
    secOut && lastCmd_q.act == blk_pkg::ACT_REVERT && lastCmd_q.cred != blk_pkg::DEF_LABEL_CRED
      |-> rspStatus == blk_pkg::STS_DENIED;
  endproperty
  a_revert: assert property (p_revert) else $error("revert without label credential");
  property p_fw;
    secOut && lastCmd_q.act == blk_pkg::ACT_FW_LOAD && lastCmd_q.flags[2:0] != 3'h7
      |-> rspStatus != blk_pkg::STS_GOOD;
  endproperty
  a_fw: assert property (p_fw) else $error("unchecked image accepted");
  property p_enable;
    secOut && lastCmd_q.act == blk_pkg::ACT_ENABLE && lastCmd_q.band < 4'h2 |-> rspStatus != blk_pkg::STS_GOOD;
  endproperty
  a_enable: assert property (p_enable) else $error("enable of band 0 or 1 accepted");
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected %s expected %h seen %h", n, e, g); end end
module tb;
  typedef struct {
    logic [7:0] op;
    logic [11:0] abf;
    int cs;
    logic [47:0] lba;
    logic [47:0] len;
    logic pl;
    logic [1:0] st;
    logic pulse;
  } blk_row_t;
  localparam logic [1:0] OK = blk_pkg::STS_GOOD;
  localparam logic [1:0] DN = blk_pkg::STS_DENIED;
  localparam logic [1:0] RF = blk_pkg::STS_REFUSED;
  localparam logic [1:0] BD = blk_pkg::STS_BAD;
  localparam logic [255:0] NEW_CRED = {8{32'h1234_abcd}};
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic powerLoss = 1'b0;
  logic reqValid = 1'b0;
  blk_pkg::blk_cmd_t reqCmd = '0;
  logic reqReady, rspValid, misalignWarn, mediaStrobe, mediaWrite, fwAccept;
  logic [1:0] rspStatus;
  logic [255:0] rspData, mediaKey;
  logic [3:0] mediaBand;
  int err_count = 0;
  int n_checks = 0;
  int pulses = 0;
  int cycles = 0;
  blk_row_t rows[$];
  blk_link_if link ();
  blk_device blk_device_inst (.mclk(mclk), .rst(rst), .link(link.dev), .powerLoss(powerLoss), .mediaKey(mediaKey),
    .mediaBand(mediaBand), .mediaStrobe(mediaStrobe), .mediaWrite(mediaWrite), .fwAccept(fwAccept));
  blk_host blk_host_inst (.mclk(mclk), .rst(rst), .link(link.host), .reqValid(reqValid), .reqReady(reqReady),
    .reqCmd(reqCmd), .rspValid(rspValid), .rspStatus(rspStatus), .rspData(rspData), .misalignWarn(misalignWarn));
  blk_link_properties blk_link_properties_inst (.mclk(mclk), .rst(rst), .cmdValid(link.cmdValid),
    .cmdReady(link.cmdReady), .cmd(link.cmd), .rspValid(link.rspValid), .rspStatus(link.rspStatus),
    .rspData(link.rspData));
  initial begin
    forever #5 mclk = ~mclk;
  end
  // ---------------------------------------------------------------
  // pulse counter and hang limit
  // ---------------------------------------------------------------
  always @(posedge mclk) begin
    pulses <= pulses + ((mediaStrobe === 1'b1 || fwAccept === 1'b1) ? 1 : 0);
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_count++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  function automatic logic [255:0] cr(int s);
    case (s)
      1: return blk_pkg::DEF_FACTORY_CRED;
      2: return blk_pkg::DEF_LABEL_CRED;
      3: return NEW_CRED;
      default: return '0;
    endcase
  endfunction
  // abf packs action, band and flags, one hex digit each
  task automatic add(logic [7:0] op, logic [11:0] abf, int cs, logic [15:0] lba, logic [15:0] len, logic pl,
      logic [1:0] st, logic pulse);
    rows.push_back('{op, abf, cs, 48'(lba), 48'(len), pl, st, pulse});
  endtask
  task automatic run(blk_row_t r);
    int n;
    int p;
    p = pulses;
    n = 0;
    @(negedge mclk);
    powerLoss = r.pl;
    reqValid = 1'b1;
    reqCmd = '0;
    {reqCmd.op, reqCmd.act, reqCmd.band, reqCmd.flags} = {r.op, r.abf};
    reqCmd.cred = cr(r.cs);
    reqCmd.arg = NEW_CRED;
    reqCmd.lba = r.lba;
    reqCmd.len = r.len;
    // ready seen at the falling edge is what the next rising edge takes
    while (reqReady !== 1'b1 && n < 50) begin
      @(negedge mclk);
      n++;
    end
    @(negedge mclk);
    powerLoss = 1'b0;
    reqValid = 1'b0;
    `CHK("link opcode", r.op, link.cmd.op)
    n = 0;
    while (rspValid !== 1'b1 && n < 60) begin
      @(negedge mclk);
      n++;
    end
    `CHK("answer", 1'b1, rspValid)
    `CHK("status", r.st, rspStatus)
    `CHK("media pulse", r.pulse, 1'(pulses != p))
    if (r.op == 8'ha2 && r.abf[11:8] == 4'h1) `CHK("factory", blk_pkg::DEF_FACTORY_CRED, rspData)
    else if (r.op != 8'ha2) `CHK("data", 256'h0, rspData)
    if (r.op == 8'hb5 && r.abf[11:8] == 4'h2) `CHK("warn", |(r.lba[11:0] | r.len[11:0]), misalignWarn)
    if (r.pulse && r.op != 8'hb5) begin
      `CHK("band", r.abf[7:4], mediaBand)
      `CHK("write", 1'(r.op == 8'h2a), mediaWrite)
    end
  endtask
  initial begin
    int k;
    int j;
    repeat (8) @(negedge mclk);
    `CHK("ready in reset", 1'b0, reqReady)
    rst = 1'b0;
    add(8'h28, 12'h000, 0, 16'h0005, 16'h0, 0, OK, 1);
    add(8'ha2, 12'h100, 0, 16'h0, 16'h0, 0, OK, 0);
    add(8'ha2, 12'h000, 0, 16'h0, 16'h0, 0, OK, 0);
    add(8'hb5, 12'h000, 0, 16'h0, 16'h0, 0, DN, 0);
    add(8'hb5, 12'h000, 1, 16'h0, 16'h0, 0, OK, 0);
    add(8'hb5, 12'h100, 1, 16'h0, 16'h0, 0, OK, 0);
    add(8'hb5, 12'h707, 0, 16'h0, 16'h0, 0, RF, 0);
    add(8'hb5, 12'h101, 3, 16'h0, 16'h0, 0, OK, 0);
    add(8'hb5, 12'h703, 0, 16'h0, 16'h0, 0, RF, 0);
    add(8'hb5, 12'h707, 0, 16'h0, 16'h0, 0, OK, 1);
    add(8'hb5, 12'h210, 1, 16'h1000, 16'h1000, 0, OK, 0);
    add(8'hb5, 12'h310, 1, 16'h0, 16'h0, 0, BD, 0);
    add(8'hb5, 12'h220, 1, 16'h2000, 16'h1000, 0, RF, 0);
    add(8'hb5, 12'h320, 1, 16'h0, 16'h0, 0, OK, 0);
    add(8'hb5, 12'h220, 1, 16'h1fff, 16'h1000, 0, RF, 0);
    add(8'hb5, 12'h220, 1, 16'h2000, 16'h1000, 0, OK, 0);
    add(8'h28, 12'h010, 0, 16'h1fff, 16'h0, 0, OK, 1);
    add(8'h2a, 12'h020, 0, 16'h2000, 16'h0, 0, OK, 1);
    add(8'hb5, 12'h417, 1, 16'h0, 16'h0, 0, OK, 0);
    add(8'h28, 12'h010, 0, 16'h1800, 16'h0, 1, RF, 0);
    add(8'h2a, 12'h010, 0, 16'h1800, 16'h0, 0, RF, 0);
    add(8'h28, 12'h020, 0, 16'h2800, 16'h0, 0, OK, 1);
    add(8'hb5, 12'h418, 1, 16'h0, 16'h0, 0, OK, 0);
    add(8'h28, 12'h010, 0, 16'h1800, 16'h0, 0, OK, 1);
    add(8'hb5, 12'h510, 0, 16'h0, 16'h0, 0, DN, 0);
    add(8'hb5, 12'h510, 1, 16'h0, 16'h0, 0, OK, 0);
    add(8'h48, 12'h200, 0, 16'h0, 16'h0, 0, BD, 0);
    add(8'h48, 12'h300, 0, 16'h0, 16'h0, 0, OK, 0);
    add(8'hb5, 12'h600, 1, 16'h0, 16'h0, 0, DN, 0);
    add(8'hb5, 12'h600, 2, 16'h0, 16'h0, 0, OK, 0);
    add(8'hb5, 12'h101, 3, 16'h0, 16'h0, 0, DN, 0);
    add(8'h28, 12'h000, 0, 16'h1800, 16'h0, 0, OK, 1);
    foreach (rows[i]) begin
      run(rows[i]);
    end
    // ---------------------------------------------------------------
    // mid-run reset, then a burst that backs up behind two key walks
    // ---------------------------------------------------------------
    @(negedge mclk);
    rst = 1'b1;
    @(negedge mclk);
    `CHK("ready in reset", 1'b0, reqReady)
    rst = 1'b0;
    reqCmd = '0;
    k = 0;
    j = 0;
    // sanitize first: its walk stalls the pop side until the buffer refuses
    for (int i = 1; i <= 50; i++) begin
      @(negedge mclk);
      if (mediaStrobe === 1'b1) begin
        if (j == 0) `CHK("walk wait", 35, i)
        `CHK("burst order", j[0], mediaWrite)
        j++;
      end
      reqValid = (k < 11);
      reqCmd.op = (k == 0) ? blk_pkg::OP_SANITIZE : (k[0] ? blk_pkg::OP_READ : blk_pkg::OP_WRITE);
      reqCmd.act = (k == 0) ? blk_pkg::SAN_CRYPT : 4'h0;
      if (reqValid && reqReady === 1'b1) k++;
    end
    `CHK("burst count", 10, j)
    print_verdict();
  end
endmodule
`default_nettype wire
